// *** rtl/dphi_pkg.sv ***
package dphi_pkg;

    // Byte framing
    localparam int          BYTE_W        = 8;
    localparam logic [3:0]  I2C_BYTE_DONE = 4'h8;
    localparam logic [3:0]  I2C_CNT_ONE   = 4'h1;
    localparam logic [2:0]  SPI_BIT_LAST  = 3'h7;
    localparam logic [2:0]  SPI_BIT_MSB   = 3'h7;
    localparam logic [2:0]  SPI_BYTE_MAX  = 3'h7;
    localparam logic [2:0]  SPI_CNT_ONE   = 3'h1;

    // Interface lock field
    localparam int          LOCK_FORCE_BIT = 1;
    localparam logic [1:0]  LOCK_SPI_ONLY  = 2'h2;
    localparam logic [1:0]  LOCK_I2C_ONLY  = 2'h3;

    // Input synchroniser lanes
    localparam int          SYNC_W    = 6;
    localparam int          SY_SCL    = 0;
    localparam int          SY_SDA    = 1;
    localparam int          SY_CSN    = 2;
    localparam int          SY_AHIGH  = 3;
    localparam int          SY_ALOW   = 4;
    localparam int          SY_TOG    = 5;
    localparam logic [5:0]  SYNC_IDLE = 6'h07;

    // Link rates
    localparam int          SYS_CLK_HZ        = 40_000_000;
    localparam int          I2C_MAX_HZ        = 400_000;
    localparam int          I2C_SAMPLES_PER_BIT = SYS_CLK_HZ / I2C_MAX_HZ;
    localparam int          SPI_MIN_PERIOD_NS = 100;

    typedef enum logic [1:0] {LOCK_OPEN, LOCK_I2C, LOCK_SPI} dphi_lock_t;

    typedef enum logic [2:0] {
        I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK, I_SKIP
    } dphi_i2c_st_t;

    typedef struct packed {
        logic [7:0] data;
        logic       first;
        logic       viaSpi;
    } dphi_cmd_t;

    typedef struct packed {
        logic [7:0] status;
        logic [1:0] argBytes;
        logic       threeWire;
        logic       spiOk;
    } dphi_spi_cfg_t;

endpackage

// *** rtl/dphi_host_if.sv ***
`timescale 1ns/1ps

// Function
// - Select pin low means the link is SPI, 3-wire or 4-wire.
// - Select pin high means I2C slave answering only its own address.
// - Lock field: 0x follows first command, 10 SPI only, 11 I2C only.
// - Protocol fixed by first command holds until hard or soft reset.
// - Address is stored five bits, two address pins, then direction bit.
// - Direction bit one reads, zero writes.
// - I2C standard and fast mode up to 400 kHz.
// - Bytes travel MSB first; words are built MSByte first.
// - Ack only a matching address; otherwise wait for start or stop.
// - Command byte after a matching write address is always acknowledged.
// - Device drives status byte; master does not acknowledge, then stops.
// - SPI accepted at up to 10 MHz, 100 ns clock period.
// - SPI is half-duplex like I2C, allowing one shared data line.
// - SPI mode 3: idle high, drive on leading, sample on trailing edge.
// - SPI chip select is active low; selected only while low.
// - Every accepted command yields a status byte readable first.
module dphi_host_if (
    // System
    input  wire logic               clk_sys,
    input  wire logic               resetn,
    // Core side
    input  wire logic [4:0]         storedAddressBits,
    input  wire logic [1:0]         interfaceLockSelect,
    input  wire logic               softReset,
    input  wire logic [7:0]         statusByte,
    input  wire logic [1:0]         spiArgBytes,
    input  wire logic               spiThreeWire,
    output dphi_pkg::dphi_cmd_t     cmdWord,
    output logic                    cmdValid,
    output dphi_pkg::dphi_lock_t    lockState,
    // Pins
    input  wire logic               protocolSelectN,
    input  wire logic               addressPinHigh,
    input  wire logic               addressPinLow,
    input  wire logic               sclIn,
    input  wire logic               sdaIn,
    output logic                    sdaOut,
    output logic                    sdaDriveN,
    input  wire logic               spiClk,
    output logic                    misoOut,
    output logic                    misoDriveN,
    output logic                    sdaSpiOut,
    output logic                    sdaSpiDriveN
);
    import dphi_pkg::*;

    // Reset release
    logic [1:0]             rstPipe_q;
    logic                   rstN;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rstPipe_q <= 2'h0;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstN = rstPipe_q[1];

    // Input synchronisers, three stages, change taken when stages two and three agree
    logic                   rxTog_q;
    logic [SYNC_W-1:0]      syncIn;
    logic [SYNC_W-1:0]      sy1_q;
    logic [SYNC_W-1:0]      sy2_q;
    logic [SYNC_W-1:0]      sy3_q;
    logic [SYNC_W-1:0]      filt_q;

    assign syncIn = {rxTog_q, addressPinLow, addressPinHigh, protocolSelectN, sdaIn, sclIn};

    for (genvar g = 0; g < SYNC_W; g++) begin : gSync
        always_ff @(posedge clk_sys or negedge rstN) begin
            if (!rstN) begin
                sy1_q[g]  <= SYNC_IDLE[g];
                sy2_q[g]  <= SYNC_IDLE[g];
                sy3_q[g]  <= SYNC_IDLE[g];
                filt_q[g] <= SYNC_IDLE[g];
            end else begin
                sy1_q[g]  <= syncIn[g];
                sy2_q[g]  <= sy1_q[g];
                sy3_q[g]  <= sy2_q[g];
                filt_q[g] <= (sy2_q[g] == sy3_q[g]) ? sy3_q[g] : filt_q[g];
            end
        end
    end

    logic sclF;
    logic sdaF;
    logic csnF;
    assign sclF = filt_q[SY_SCL];
    assign sdaF = filt_q[SY_SDA];
    assign csnF = filt_q[SY_CSN];

    // SPI receive side, written on the trailing (rising) clock edge
    logic [2:0]             sBit_q, sBit_d;
    logic [2:0]             sByte_q, sByte_d;
    logic [6:0]             sShift_q, sShift_d;
    logic [7:0]             rxByte_q, rxByte_d;
    logic                   rxFirst_q, rxFirst_d;
    logic                   rxTog_d;
    dphi_spi_cfg_t          cfg_q, cfg_d;

    always_comb begin
        sBit_d    = sBit_q + SPI_CNT_ONE;
        sShift_d  = {sShift_q[5:0], sdaIn};
        sByte_d   = sByte_q;
        rxByte_d  = rxByte_q;
        rxFirst_d = rxFirst_q;
        rxTog_d   = rxTog_q;
        if (sBit_q == SPI_BIT_LAST) begin
            rxByte_d  = {sShift_q, sdaIn};
            rxFirst_d = (sByte_q == 3'h0);
            rxTog_d   = ~rxTog_q;
            sByte_d   = (sByte_q == SPI_BYTE_MAX) ? sByte_q : sByte_q + SPI_CNT_ONE;
        end
    end

    // Counters restart with every frame: chip select high clears them
    always_ff @(posedge spiClk or posedge protocolSelectN) begin
        if (protocolSelectN) begin
            sBit_q   <= 3'h0;
            sByte_q  <= 3'h0;
            sShift_q <= 7'h00;
        end else begin
            sBit_q   <= sBit_d;
            sByte_q  <= sByte_d;
            sShift_q <= sShift_d;
        end
    end

    always_ff @(posedge spiClk or negedge resetn) begin
        if (!resetn) begin
            rxByte_q  <= 8'h00;
            rxFirst_q <= 1'b0;
            rxTog_q   <= 1'b0;
        end else begin
            rxByte_q  <= rxByte_d;
            rxFirst_q <= rxFirst_d;
            rxTog_q   <= rxTog_d;
        end
    end

    // SPI transmit side, driven on the leading (falling) clock edge
    logic                   sDrive;
    logic                   sOut;
    logic                   misoOut_q, misoDriveN_q;
    logic                   sdaSpiOut_q, sdaSpiDriveN_q;

    always_comb begin
        sDrive = cfg_q.spiOk && (sByte_q == ({1'b0, cfg_q.argBytes} + SPI_CNT_ONE));
        sOut   = cfg_q.status[SPI_BIT_MSB - sBit_q];
    end

    always_ff @(negedge spiClk or posedge protocolSelectN) begin
        if (protocolSelectN) begin
            misoOut_q      <= 1'b0;
            misoDriveN_q   <= 1'b1;
            sdaSpiOut_q    <= 1'b0;
            sdaSpiDriveN_q <= 1'b1;
        end else begin
            misoOut_q      <= sOut;
            misoDriveN_q   <= ~(sDrive && !cfg_q.threeWire);
            sdaSpiOut_q    <= sOut;
            sdaSpiDriveN_q <= ~(sDrive && cfg_q.threeWire);
        end
    end

    // Protocol engine on clk_sys: I2C slave, SPI byte intake, lock
    dphi_i2c_st_t           i2cSt_q, i2cSt_d;
    logic [3:0]             bitCnt_q, bitCnt_d;
    logic [7:0]             shift_q, shift_d;
    logic                   rdMode_q, rdMode_d;
    logic                   ackSeen_q, ackSeen_d;
    logic                   firstCmd_q, firstCmd_d;
    logic                   sdaDriveN_q, sdaDriveN_d;
    logic                   sdaOut_q;
    logic                   sclPrev_q, sdaPrev_q;
    logic                   togSeen_q;
    dphi_cmd_t              cmd_q, cmd_d;
    logic                   cmdValid_q, cmdValid_d;
    dphi_lock_t             lock_q, lock_d;
    logic                   sclRise, sclFall, startC, stopC;
    logic                   i2cOk, spiOk, i2cGate, spiEvt;
    logic [6:0]             myAddr;

    always_comb begin
        sclRise = sclF && !sclPrev_q;
        sclFall = !sclF && sclPrev_q;
        startC  = sclF && sclPrev_q && sdaPrev_q && !sdaF;
        stopC   = sclF && sclPrev_q && !sdaPrev_q && sdaF;
        myAddr  = {storedAddressBits, filt_q[SY_AHIGH], filt_q[SY_ALOW]};
        if (interfaceLockSelect[LOCK_FORCE_BIT]) begin
            i2cOk = (interfaceLockSelect == LOCK_I2C_ONLY);
            spiOk = (interfaceLockSelect == LOCK_SPI_ONLY);
        end else begin
            i2cOk = (lock_q != LOCK_SPI);
            spiOk = (lock_q != LOCK_I2C);
        end
        i2cGate = csnF && i2cOk;
        spiEvt  = (filt_q[SY_TOG] != togSeen_q);

        i2cSt_d     = i2cSt_q;
        bitCnt_d    = bitCnt_q;
        shift_d     = shift_q;
        rdMode_d    = rdMode_q;
        ackSeen_d   = ackSeen_q;
        firstCmd_d  = firstCmd_q;
        sdaDriveN_d = sdaDriveN_q;
        cmd_d       = cmd_q;
        cmdValid_d  = 1'b0;
        cfg_d       = cfg_q;

        if (!i2cGate) begin
            i2cSt_d     = I_IDLE;
            sdaDriveN_d = 1'b1;
        end else if (startC) begin
            i2cSt_d     = I_ADDR;
            bitCnt_d    = 4'h0;
            sdaDriveN_d = 1'b1;
        end else if (stopC) begin
            i2cSt_d     = I_IDLE;
            sdaDriveN_d = 1'b1;
        end else begin
            unique case (i2cSt_q)
                I_IDLE, I_SKIP: begin
                end
                I_ADDR: begin
                    if (sclRise) begin
                        shift_d  = {shift_q[6:0], sdaF};
                        bitCnt_d = bitCnt_q + I2C_CNT_ONE;
                    end else if (sclFall && bitCnt_q == I2C_BYTE_DONE) begin
                        if (shift_q[7:1] == myAddr) begin
                            i2cSt_d     = I_AACK;
                            sdaDriveN_d = 1'b0;
                            rdMode_d    = shift_q[0];
                        end else begin
                            i2cSt_d = I_SKIP;
                        end
                    end
                end
                I_AACK: begin
                    if (sclFall) begin
                        bitCnt_d = 4'h0;
                        if (rdMode_q) begin
                            i2cSt_d     = I_RD;
                            shift_d     = statusByte;
                            sdaDriveN_d = statusByte[BYTE_W-1];
                        end else begin
                            i2cSt_d     = I_WR;
                            sdaDriveN_d = 1'b1;
                            firstCmd_d  = 1'b1;
                        end
                    end
                end
                I_WR: begin
                    if (sclRise) begin
                        shift_d  = {shift_q[6:0], sdaF};
                        bitCnt_d = bitCnt_q + I2C_CNT_ONE;
                    end else if (sclFall && bitCnt_q == I2C_BYTE_DONE) begin
                        i2cSt_d     = I_WACK;
                        sdaDriveN_d = 1'b0;
                        cmdValid_d  = 1'b1;
                        cmd_d       = '{data: shift_q, first: firstCmd_q, viaSpi: 1'b0};
                        firstCmd_d  = 1'b0;
                    end
                end
                I_WACK: begin
                    if (sclFall) begin
                        i2cSt_d     = I_WR;
                        sdaDriveN_d = 1'b1;
                        bitCnt_d    = 4'h0;
                    end
                end
                I_RD: begin
                    if (sclRise) begin
                        bitCnt_d = bitCnt_q + I2C_CNT_ONE;
                    end else if (sclFall) begin
                        if (bitCnt_q == I2C_BYTE_DONE) begin
                            i2cSt_d     = I_RACK;
                            sdaDriveN_d = 1'b1;
                        end else begin
                            shift_d     = {shift_q[6:0], 1'b0};
                            sdaDriveN_d = shift_q[BYTE_W-2];
                        end
                    end
                end
                I_RACK: begin
                    if (sclRise) begin
                        ackSeen_d = !sdaF;
                    end else if (sclFall) begin
                        bitCnt_d = 4'h0;
                        if (ackSeen_q) begin
                            i2cSt_d     = I_RD;
                            shift_d     = statusByte;
                            sdaDriveN_d = statusByte[BYTE_W-1];
                        end else begin
                            i2cSt_d = I_SKIP;
                        end
                    end
                end
            endcase
        end

        if (spiEvt && !csnF && spiOk) begin
            cmdValid_d = 1'b1;
            cmd_d      = '{data: rxByte_q, first: rxFirst_q, viaSpi: 1'b1};
        end

        // SPI settings are only refreshed between frames
        if (csnF) begin
            cfg_d = '{status: statusByte, argBytes: spiArgBytes,
                      threeWire: spiThreeWire, spiOk: spiOk};
        end

        lock_d = lock_q;
        if (softReset) begin
            lock_d = LOCK_OPEN;
        end else if (!interfaceLockSelect[LOCK_FORCE_BIT] && lock_q == LOCK_OPEN
                     && cmdValid_d && cmd_d.first) begin
            lock_d = cmd_d.viaSpi ? LOCK_SPI : LOCK_I2C;
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            i2cSt_q     <= I_IDLE;
            bitCnt_q    <= 4'h0;
            shift_q     <= 8'h00;
            rdMode_q    <= 1'b0;
            ackSeen_q   <= 1'b0;
            firstCmd_q  <= 1'b0;
            sdaDriveN_q <= 1'b1;
            sdaOut_q    <= 1'b0;
            sclPrev_q   <= 1'b1;
            sdaPrev_q   <= 1'b1;
            togSeen_q   <= 1'b0;
            cmd_q       <= '0;
            cmdValid_q  <= 1'b0;
            lock_q      <= LOCK_OPEN;
            cfg_q       <= '0;
        end else begin
            i2cSt_q     <= i2cSt_d;
            bitCnt_q    <= bitCnt_d;
            shift_q     <= shift_d;
            rdMode_q    <= rdMode_d;
            ackSeen_q   <= ackSeen_d;
            firstCmd_q  <= firstCmd_d;
            sdaDriveN_q <= sdaDriveN_d;
            sdaOut_q    <= 1'b0;
            sclPrev_q   <= sclF;
            sdaPrev_q   <= sdaF;
            togSeen_q   <= filt_q[SY_TOG];
            cmd_q       <= cmd_d;
            cmdValid_q  <= cmdValid_d;
            lock_q      <= lock_d;
            cfg_q       <= cfg_d;
        end
    end

    assign cmdWord      = cmd_q;
    assign cmdValid     = cmdValid_q;
    assign lockState    = lock_q;
    assign sdaOut       = sdaOut_q;
    assign sdaDriveN    = sdaDriveN_q;
    assign misoOut      = misoOut_q;
    assign misoDriveN   = misoDriveN_q;
    assign sdaSpiOut    = sdaSpiOut_q;
    assign sdaSpiDriveN = sdaSpiDriveN_q;

    AST_I2C_ONLY_WHEN_HIGH: assert property (
        @(posedge clk_sys) disable iff (!rstN)
        !sdaDriveN_q |-> $past(csnF))
        else $error("I2C data driven while select was low");

    AST_ADDR_MISMATCH_SILENT: assert property (
        @(posedge clk_sys) disable iff (!rstN)
        (i2cSt_q == I_ADDR && i2cGate && !startC && !stopC && sclFall
         && bitCnt_q == I2C_BYTE_DONE && shift_q[7:1] != myAddr)
        |=> sdaDriveN_q && i2cSt_q == I_SKIP)
        else $error("Foreign address was acknowledged");

    AST_CMD_ALWAYS_ACKED: assert property (
        @(posedge clk_sys) disable iff (!rstN)
        (i2cSt_q == I_WR && i2cGate && !startC && !stopC && sclFall
         && bitCnt_q == I2C_BYTE_DONE)
        |=> !sdaDriveN_q && cmdValid_q && cmd_q.data == $past(shift_q))
        else $error("Command byte not acknowledged or not delivered");

    AST_SPI_ONLY_BLOCKS_I2C: assert property (
        @(posedge clk_sys) disable iff (!rstN)
        (interfaceLockSelect == LOCK_SPI_ONLY) |=> sdaDriveN_q && i2cSt_q == I_IDLE)
        else $error("I2C active while locked to SPI");

    AST_LOCK_HOLDS: assert property (
        @(posedge clk_sys) disable iff (!rstN)
        (lock_q != LOCK_OPEN && !softReset) |=> lock_q == $past(lock_q))
        else $error("Protocol lock changed without reset");

    AST_DIRECTION_BIT: assert property (
        @(posedge clk_sys) disable iff (!rstN)
        (i2cSt_q == I_AACK && i2cGate && !startC && !stopC && sclFall)
        |=> i2cSt_q == ($past(rdMode_q) ? I_RD : I_WR))
        else $error("Direction bit not honoured");

    AST_STATUS_MSB_FIRST: assert property (
        @(posedge clk_sys) disable iff (!rstN)
        (i2cSt_q == I_AACK && rdMode_q && i2cGate && !startC && !stopC && sclFall)
        |=> sdaDriveN_q == $past(statusByte[BYTE_W-1]) && i2cSt_q == I_RD)
        else $error("Status byte does not start with its MSB");

    AST_SPI_STATUS_BIT: assert property (
        @(posedge spiClk) disable iff (protocolSelectN)
        !misoDriveN_q |-> misoOut_q == cfg_q.status[SPI_BIT_MSB - sBit_q])
        else $error("SPI status bit out of order");

endmodule

// *** tb/dphi_host_model.sv ***
`timescale 1ns/1ps
module dphi_host_model (
    // System
    input  wire logic clk_sys,
    // Pins toward the device
    output logic      sclIn,
    output logic      sdaIn,
    output logic      protocolSelectN,
    output logic      spiClk,
    // Device drivers
    input  wire logic sdaOut,
    input  wire logic sdaDriveN,
    input  wire logic misoOut,
    input  wire logic misoDriveN,
    input  wire logic sdaSpiOut,
    input  wire logic sdaSpiDriveN
);
    logic hostSda;
    logic misoLast;
    logic misoWire;

    initial begin
        hostSda = 1'b1;
        sclIn = 1'b1;
        protocolSelectN = 1'b0;
        spiClk = 1'b1;
        misoLast = 1'b0;
        // Real rising edge so the frame logic starts cleared, not unknown
        #1;
        protocolSelectN = 1'b1;
    end

    // Pulled-up SDA, shared with the 3-wire data line
    assign sdaIn = !sdaSpiDriveN ? sdaSpiOut : (hostSda & (sdaDriveN | sdaOut));
    // Released MISO shows the inverse of its last level
    always @(misoOut, misoDriveN) begin
        if (!misoDriveN) begin
            misoLast = misoOut;
        end
    end
    assign misoWire = misoDriveN ? ~misoLast : misoOut;

    // Quarter of a 400 kHz bit
    task automatic q();
        repeat (25) @(negedge clk_sys);
    endtask

    task automatic i2cBit(input logic b, output logic r);
        hostSda = b;
        q();
        sclIn = 1'b1;
        q();
        r = sdaIn;
        q();
        sclIn = 1'b0;
        q();
    endtask

    // Start from idle, or repeated start from SCL low
    task automatic i2cStart();
        hostSda = 1'b1;
        q();
        sclIn = 1'b1;
        q();
        hostSda = 1'b0;
        q();
        sclIn = 1'b0;
        q();
    endtask

    task automatic i2cStop();
        hostSda = 1'b0;
        q();
        sclIn = 1'b1;
        q();
        hostSda = 1'b1;
        q();
    endtask

    task automatic i2cWrite(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            i2cBit(b[i], r);
        end
        i2cBit(1'b1, r);
        ack = ~r;
    endtask

    task automatic i2cRead(input logic mAck, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            i2cBit(1'b1, r);
            b[i] = r;
        end
        i2cBit(~mAck, r);
    endtask

    // Mode-3 frame: command, arguments, then one status byte
    task automatic spiFrame(input logic [7:0] cmd, input logic [7:0] arg, input int nArg,
                            input logic three, output logic [7:0] st);
        logic [7:0] b;
        @(negedge clk_sys);
        protocolSelectN = 1'b0;
        #40;
        for (int k = 0; k <= nArg + 1; k++) begin
            b = (k == 0) ? cmd : ((k <= nArg) ? arg : 8'hFF);
            for (int i = 7; i >= 0; i--) begin
                spiClk = 1'b0;
                hostSda = b[i];
                #80;
                spiClk = 1'b1;
                st[i] = three ? sdaIn : misoWire;
                #80;
            end
        end
        #40;
        protocolSelectN = 1'b1;
        repeat (8) @(negedge clk_sys);
    endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import dphi_pkg::*;
    logic [4:0] storedAddressBits;
    logic [1:0] interfaceLockSelect;
    logic [7:0] statusByte;
    logic [1:0] spiArgBytes;
    logic       clk_sys, resetn, softReset, spiThreeWire, addressPinHigh, addressPinLow;
    dphi_cmd_t  cmdWord, firstCmd;
    dphi_lock_t lockState;
    logic       cmdValid, sclIn, sdaIn, sdaOut, sdaDriveN, spiClk, protocolSelectN;
    logic       misoOut, misoDriveN, sdaSpiOut, sdaSpiDriveN;
    logic [2:0] acks;
    logic [7:0] rd;
    logic [6:0] myAddr;
    int         badCount = 0;
    int         comparisons = 0;
    int         cmdCount = 0;
    int         held;

    dphi_host_if DUT (.clk_sys(clk_sys), .resetn(resetn), .storedAddressBits(storedAddressBits),
        .interfaceLockSelect(interfaceLockSelect), .softReset(softReset),
        .statusByte(statusByte), .spiArgBytes(spiArgBytes), .spiThreeWire(spiThreeWire),
        .cmdWord(cmdWord), .cmdValid(cmdValid), .lockState(lockState),
        .protocolSelectN(protocolSelectN), .addressPinHigh(addressPinHigh),
        .addressPinLow(addressPinLow), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
        .sdaDriveN(sdaDriveN), .spiClk(spiClk), .misoOut(misoOut), .misoDriveN(misoDriveN),
        .sdaSpiOut(sdaSpiOut), .sdaSpiDriveN(sdaSpiDriveN));

    dphi_host_model host (.clk_sys(clk_sys), .sclIn(sclIn), .sdaIn(sdaIn),
        .protocolSelectN(protocolSelectN), .spiClk(spiClk), .sdaOut(sdaOut),
        .sdaDriveN(sdaDriveN), .misoOut(misoOut), .misoDriveN(misoDriveN),
        .sdaSpiOut(sdaSpiOut), .sdaSpiDriveN(sdaSpiDriveN));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (cmdValid === 1'b1) begin
            cmdCount++;
            if (cmdWord.first === 1'b1) begin
                firstCmd <= cmdWord;
            end
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            badCount++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic endSim();
        $display("Comparisons %0d, mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Command write, repeated start, status read
    task automatic i2cCmd(input logic [6:0] addr, input logic [7:0] cmd);
        host.i2cStart();
        host.i2cWrite({addr, 1'b0}, acks[2]);
        host.i2cWrite(cmd, acks[1]);
        host.i2cStart();
        host.i2cWrite({addr, 1'b1}, acks[0]);
        host.i2cRead(1'b0, rd);
        host.i2cStop();
        repeat (8) @(negedge clk_sys);
    endtask

    task automatic spiXfer(input logic [7:0] cmd, input logic three);
        host.spiFrame(cmd, 8'h12, int'(spiArgBytes), three, rd);
    endtask

    task automatic pulseSoft(input logic [1:0] lock);
        interfaceLockSelect = lock;
        softReset = 1'b1;
        @(negedge clk_sys);
        softReset = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        badCount++;
        endSim();
    end

    initial begin
        resetn = 1'b1;
        storedAddressBits = 5'h03;
        interfaceLockSelect = 2'h0;
        softReset = 1'b0;
        statusByte = 8'hC3;
        spiArgBytes = 2'h1;
        spiThreeWire = 1'b0;
        addressPinHigh = 1'b1;
        addressPinLow = 1'b0;
        myAddr = {5'h03, 1'b1, 1'b0};
        // Real falling edge once every process waits on it
        #1;
        resetn = 1'b0;
        repeat (8) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (8) @(negedge clk_sys);
        check(lockState, LOCK_OPEN);
        check(sdaDriveN, 1'b1);
        check(sdaOut, 1'b0);
        i2cCmd(myAddr ^ 7'h01, 8'h35);
        check(acks, 3'h0);
        check(16'(cmdCount), 16'h0);
        i2cCmd(myAddr, 8'h07);
        check(acks, 3'h7);
        check(rd, 8'hC3);
        check(firstCmd, {8'h07, 1'b1, 1'b0});
        check(lockState, LOCK_I2C);
        held = cmdCount;
        spiXfer(8'h35, 1'b0);
        check(16'(cmdCount), 16'(held));
        pulseSoft(2'h1);
        check(lockState, LOCK_OPEN);
        spiXfer(8'h60, 1'b0);
        check(rd, 8'hC3);
        check(firstCmd, {8'h60, 1'b1, 1'b1});
        check(lockState, LOCK_SPI);
        i2cCmd(myAddr, 8'h07);
        check(acks, 3'h0);
        // Hard reset in mid-run reopens the lock
        resetn = 1'b0;
        repeat (4) @(negedge clk_sys);
        check(lockState, LOCK_OPEN);
        resetn = 1'b1;
        repeat (8) @(negedge clk_sys);
        spiThreeWire = 1'b1;
        spiArgBytes = 2'h0;
        statusByte = 8'h5A;
        pulseSoft(2'h0);
        spiXfer(8'h3E, 1'b1);
        check(rd, 8'h5A);
        pulseSoft(2'h3);
        held = cmdCount;
        spiXfer(8'h3E, 1'b1);
        check(16'(cmdCount), 16'(held));
        i2cCmd(myAddr, 8'h07);
        check(acks, 3'h7);
        pulseSoft(2'h2);
        i2cCmd(myAddr, 8'h07);
        check(acks, 3'h0);
        spiXfer(8'h3E, 1'b1);
        check(rd, 8'h5A);
        endSim();
    end
endmodule
